/* dv/wdt_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_top_asserts
    import wdt_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Request and status
    input wire logic              wdog_reset_req,
    input wire logic              wdog_running
);
    // ========================================================================
    // Shadow of the write-once timeout code
    // ========================================================================
    logic       lock_q;
    logic [1:0] tsel_q;
    logic       key_bad;
    logic       rd_stat;

    // Only the first option-one write after reset is kept
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_q <= 1'b0;
            tsel_q <= TSEL_RESET;
        end else if (reg_wr && reg_addr == ADDR_SYS_OPT_ONE && !lock_q) begin
            lock_q <= 1'b1;
            tsel_q <= reg_wdata[SYSTEM_OPTIONS_ONE_TSEL_LSB +: 2];
        end
    end

    // Status-address decodes
    assign key_bad = reg_wr && reg_addr == ADDR_RESET_STATUS && reg_wdata != KEY_FIRST && reg_wdata != KEY_SECOND;
    assign rd_stat = reg_rd && reg_addr == ADDR_RESET_STATUS;

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    rst_exit_a: assert property ($fell(rst) |-> wdog_running && !wdog_reset_req)
        else $error("watchdog not running or request set after reset");
    bad_key_a: assert property (key_bad |=> wdog_reset_req)
        else $error("bad status write gave no reset request");
    req_hold_a: assert property (wdog_reset_req |=> wdog_reset_req)
        else $error("reset request dropped before reset");
    opt_read_a: assert property (reg_rd && reg_addr == ADDR_SYS_OPT_ONE |=> reg_rdata[7:6] == tsel_q)
        else $error("timeout code readback differs from first write");
    run_match_a: assert property (wdog_running == (tsel_q != TSEL_OFF))
        else $error("running flag disagrees with timeout code");
    run_lock_a: assert property (!wdog_running |=> !wdog_running)
        else $error("disabled watchdog restarted without reset");
    off_quiet_a: assert property (!wdog_running ##1 (!wdog_running && !wdog_reset_req
        && !(reg_wr && reg_addr == ADDR_RESET_STATUS)) |=> !wdog_reset_req)
        else $error("reset request while disabled");
    stat_ro_a: assert property (rd_stat ##1 (reg_wr && reg_addr == ADDR_RESET_STATUS) ##1 rd_stat
        |=> reg_rdata == $past(reg_rdata, 2))
        else $error("status contents changed by key write");

    // Main scenarios reached
    cover property ($rose(wdog_reset_req));
    cover property (!wdog_running);
    cover property (key_bad);
endmodule : wdt_top_asserts

bind wdt_top wdt_top_asserts i_wdt_top_asserts (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wdog_reset_req(wdog_reset_req), .wdog_running(wdog_running));
`default_nettype wire

/* dv/wdt_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_top_test
    import wdt_pkg::*;
;
    // ========================================================================
    // Stimulus and observed signals
    // ========================================================================
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              low_power_osc = 1'b0;
    logic              stop_mode = 1'b0;
    logic              debug_mode = 1'b0;
    logic              por_cause = 1'b1;
    logic              pin_cause = 1'b0;
    logic              lvd_cause = 1'b0;
    logic              zero = 1'b0;
    logic              wdog_reset_req;
    logic              wdog_running;
    logic [7:0]        rv;
    logic [7:0]        rw;
    int                fail_count = 0;
    int                cmp_count = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    // Bus counts shortened: overflow 16 << code, window at three quarters
    wdt_top #(.BUS_OVF_1(19'h00020), .BUS_OVF_2(19'h00040), .BUS_OVF_3(19'h00080),
              .BUS_WIN_1(19'h00018), .BUS_WIN_2(19'h00030), .BUS_WIN_3(19'h00060)) i_wdt_top (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_power_osc(low_power_osc), .stop_mode(stop_mode),
        .debug_mode(debug_mode), .por_cause(por_cause), .pin_cause(pin_cause), .lvd_cause(lvd_cause),
        .ilop_cause(zero), .ilad_cause(zero), .wdog_reset_req(wdog_reset_req), .wdog_running(wdog_running));

    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Sampled 1 ns after the edge so the design's updates have landed
    task automatic chk_req(input logic exp);
        #1 check({7'h00, wdog_reset_req}, {7'h00, exp});
    endtask : chk_req

    task automatic chk_run(input logic exp);
        #1 check({7'h00, wdog_running}, {7'h00, exp});
    endtask : chk_run

    // Bounded wait; a missing request ends the run
    task automatic wait_req(input int n);
        for (int i = 0; i < n; i++) begin
            #1;
            if (wdog_reset_req === 1'b1) break;
            cyc(1);
        end
        chk_req(1'b1);
        if (wdog_reset_req !== 1'b1) test_done();
    endtask : wait_req

    task automatic do_reset(input logic por);
        por_cause <= por;
        rst       <= 1'b1;
        cyc(3);
        rst       <= 1'b0;
        por_cause <= 1'b0;
        cyc(1);
    endtask : do_reset

    // A gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        cyc(1);
        reg_wr    <= 1'b0;
        cyc(1);
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        cyc(1);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
        cyc(1);
    endtask : rd

    task automatic svc();
        wr(ADDR_RESET_STATUS, KEY_FIRST);
        wr(ADDR_RESET_STATUS, KEY_SECOND);
    endtask : svc

    task automatic setup(input logic [1:0] code, input logic [7:0] opt2);
        do_reset(1'b0);
        wr(ADDR_SYS_OPT_ONE, {code, 6'h00});
        wr(ADDR_SYS_OPT_TWO, opt2);
    endtask : setup

    // Slow clock edges, 20 bus cycles each; stands low between bursts
    task automatic osc(input int n);
        repeat (n) begin
            low_power_osc <= 1'b1;
            cyc(10);
            low_power_osc <= 1'b0;
            cyc(10);
        end
    endtask : osc

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_defaults();
        rd(ADDR_SYS_OPT_ONE, rv);
        check(rv, 8'hC0);
        rd(ADDR_SYS_OPT_TWO, rv);
        check(rv, 8'h00);
        chk_run(1'b1);
        rd(ADDR_RESET_STATUS, rv);
        check(rv, 8'h80);
        rd(2'h3, rv);
        check(rv, 8'h00);
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_bad_key();
        do_reset(1'b0);
        reg_rd   <= 1'b1;
        reg_addr <= ADDR_RESET_STATUS;
        cyc(1);
        reg_rd    <= 1'b0;
        reg_wr    <= 1'b1;
        reg_wdata <= KEY_FIRST;
        #1 rv = reg_rdata;
        cyc(1);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        #1 rw = reg_rdata;
        cyc(1);
        check(rw, rv);
        wr(ADDR_RESET_STATUS, KEY_SECOND);
        rd(ADDR_RESET_STATUS, rw);
        check(rw, rv);
        chk_req(1'b0);
        wr(ADDR_RESET_STATUS, 8'h12);
        wait_req(3);
        do_reset(1'b0);
        rd(ADDR_RESET_STATUS, rv);
        check(rv, 8'h20);
        pin_cause <= 1'b1;
        lvd_cause <= 1'b1;
        do_reset(1'b0);
        pin_cause <= 1'b0;
        lvd_cause <= 1'b0;
        rd(ADDR_RESET_STATUS, rv);
        check(rv, 8'h42);
        $display("test bad key done");
    endtask : t_bad_key

    task automatic t_codes();
        for (int c = 1; c <= 3; c++) begin
            setup(c[1:0], 8'h80);
            cyc((16 << c) - 4);
            chk_req(1'b0);
            wait_req(8);
        end
        $display("test codes done");
    endtask : t_codes

    task automatic t_service();
        setup(2'h1, 8'h80);
        repeat (4) begin
            cyc(20);
            svc();
        end
        chk_req(1'b0);
        wr(ADDR_SYS_OPT_ONE, 8'h00);
        chk_run(1'b1);
        svc();
        cyc(14);
        wr(ADDR_RESET_STATUS, KEY_SECOND);
        cyc(12);
        chk_req(1'b0);
        wait_req(8);
        $display("test service done");
    endtask : t_service

    task automatic t_window();
        setup(2'h1, 8'hC0);
        repeat (2) begin
            cyc(26);
            svc();
        end
        chk_req(1'b0);
        cyc(4);
        wr(ADDR_RESET_STATUS, KEY_FIRST);
        wait_req(3);
        $display("test window done");
    endtask : t_window

    task automatic t_off();
        setup(TSEL_OFF, 8'h80);
        chk_run(1'b0);
        wr(ADDR_SYS_OPT_ONE, 8'h40);
        cyc(150);
        chk_req(1'b0);
        chk_run(1'b0);
        rd(ADDR_SYS_OPT_ONE, rv);
        check(rv, 8'h00);
        $display("test disabled done");
    endtask : t_off

    task automatic t_stop();
        setup(2'h1, 8'h80);
        cyc(16);
        stop_mode <= 1'b1;
        cyc(40);
        chk_req(1'b0);
        stop_mode <= 1'b0;
        cyc(10);
        chk_req(1'b0);
        wait_req(12);
        $display("test stop done");
    endtask : t_stop

    task automatic t_slow();
        setup(2'h1, 8'h40);
        osc(20);
        svc();
        chk_req(1'b0);
        osc(24);
        debug_mode <= 1'b1;
        cyc(5);
        debug_mode <= 1'b0;
        osc(30);
        chk_req(1'b0);
        osc(4);
        wait_req(8);
        $display("test slow clock done");
    endtask : t_slow

    // Main sequence
    initial begin
        do_reset(1'b1);
        t_defaults();
        t_bad_key();
        t_codes();
        t_service();
        t_window();
        t_off();
        t_stop();
        t_slow();
        test_done();
    end
endmodule : wdt_top_test
`default_nettype wire

/* hw/wdt_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_counter
    import wdt_pkg::*;
#(
    parameter int W = CNT_W
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Control
    input  wire logic         clear,
    input  wire logic         inc,
    // Count
    output logic [W-1:0]      count
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } wdt_cnt_t;

    wdt_cnt_t c_q;
    wdt_cnt_t c_d;

    // ========================================================================
    // Clear beats increment; wraps past its top, since overflow does not clear it
    // ========================================================================
    always_comb begin
        c_d = c_q;
        if (rst || clear) begin
            c_d.cnt = '0;
        end else if (inc) begin
            c_d.cnt = c_q.cnt + W'(1);
        end
    end

    assign count = c_q.cnt;

    always_ff @(posedge clk) begin
        c_q <= c_d;
    end

endmodule : wdt_counter
`default_nettype wire

/* hw/wdt_lpo_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module wdt_lpo_sync
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Slow clock in, one-cycle rising edge out
    input  wire logic lpo_in,
    output logic      lpo_tick
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } wdt_sync_t;

    wdt_sync_t s_q;
    wdt_sync_t s_d;

    // ========================================================================
    // Three-stage capture; a level counts once stages two and three agree
    // ========================================================================
    always_comb begin
        s_d     = s_q;
        s_d.s1  = lpo_in;
        s_d.s2  = s_q.s1;
        s_d.s3  = s_q.s2;
        if (s_q.s2 == s_q.s3) begin
            s_d.lvl = s_q.s3;
        end
        if (rst) begin
            s_d = '0;
        end
    end

    // Rising edge of the accepted level
    assign lpo_tick = (s_q.s2 == s_q.s3) && s_q.s3 && !s_q.lvl;

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

endmodule : wdt_lpo_sync
`default_nettype wire

/* hw/wdt_pkg.sv */
package wdt_pkg;

    // ========================================================================
    // Register map (register index = address)
    // ========================================================================
    localparam int          ADDR_W            = 2;
    localparam int          DATA_W            = 8;
    localparam logic [1:0]  ADDR_RESET_STATUS = 2'h0;
    localparam logic [1:0]  ADDR_SYS_OPT_ONE  = 2'h1;
    localparam logic [1:0]  ADDR_SYS_OPT_TWO  = 2'h2;

    // ========================================================================
    // Service keys
    // ========================================================================
    localparam logic [7:0]  KEY_FIRST         = 8'h55;
    localparam logic [7:0]  KEY_SECOND        = 8'hAA;

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int          SYSTEM_OPTIONS_ONE_TSEL_LSB    = 6;
    localparam int          SYSTEM_OPTIONS_TWO_CLKSEL_BIT  = 7;
    localparam int          SYSTEM_OPTIONS_TWO_WIN_BIT     = 6;
    localparam int          SRS_POR_BIT       = 7;
    localparam int          SRS_PIN_BIT       = 6;
    localparam int          SRS_WDOG_BIT      = 5;
    localparam int          SRS_ILOP_BIT      = 4;
    localparam int          SRS_ILAD_BIT      = 3;
    localparam int          SRS_LVD_BIT       = 1;

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [1:0]  TSEL_RESET        = 2'h3;
    localparam logic        CLKSEL_RESET      = 1'b0;
    localparam logic        WIN_RESET         = 1'b0;

    // Timeout select codes and clock select values
    localparam logic [1:0]  TSEL_OFF          = 2'h0;
    localparam logic [1:0]  TSEL_SHORT        = 2'h1;
    localparam logic [1:0]  TSEL_MID          = 2'h2;
    localparam logic        CLKSEL_LPO        = 1'b0;
    localparam logic        CLKSEL_BUS        = 1'b1;

    // ========================================================================
    // Timing counts
    // ========================================================================
    localparam int          CNT_W             = 19;
    localparam logic [18:0] LPO_OVF_SHORT     = 19'h00020;
    localparam logic [18:0] LPO_OVF_MID       = 19'h00100;
    localparam logic [18:0] LPO_OVF_LONG      = 19'h00400;
    localparam logic [18:0] BUS_OVF_SHORT     = 19'h02000;
    localparam logic [18:0] BUS_OVF_MID       = 19'h10000;
    localparam logic [18:0] BUS_OVF_LONG      = 19'h40000;
    localparam logic [18:0] BUS_WIN_SHORT     = 19'h01800;
    localparam logic [18:0] BUS_WIN_MID       = 19'h0C000;
    localparam logic [18:0] BUS_WIN_LONG      = 19'h30000;

endpackage : wdt_pkg

/* hw/wdt_top.sv */
// Behaviour
// - Watchdog runs after every reset with no setup needed.
// - Writing 0x55 then 0xAA to the status address restarts the timeout.
// - Service writes never change the readable status contents.
// - Counter reaching the selected overflow count requests a system reset.
// - Any other value written to the status address resets at once.
// - Clock select 0 picks the 1 kHz source, 1 picks the bus clock.
// - Timeout code 0 disables the watchdog; no timeout reset then.
// - 1 kHz source: codes 1,2,3 give 2^5, 2^8, 2^10 cycles.
// - Bus clock: codes 1,2,3 give 2^13, 2^16, 2^18 cycles.
// - Reset default is the 1 kHz source with the longest timeout.
// - Bus clock plus window bit: service only in last quarter.
// - Window opens at 6144, 49152 or 196608 counted bus cycles.
// - Windowed service before the window opens resets at once.
// - Window bit has no effect with the 1 kHz source.
// - Only first write to each option register after reset counts.
// - Bus clock: counter holds in stop or debug, resumes after.
// - 1 kHz source: counter cleared in stop or debug, restarts from zero.
// - Watchdog resets are recorded in their own status bit.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module wdt_top
    import wdt_pkg::*;
#(
    // Long bus-clock counts, shortened in simulation
    parameter logic [CNT_W-1:0] BUS_OVF_1 = BUS_OVF_SHORT,
    parameter logic [CNT_W-1:0] BUS_OVF_2 = BUS_OVF_MID,
    parameter logic [CNT_W-1:0] BUS_OVF_3 = BUS_OVF_LONG,
    parameter logic [CNT_W-1:0] BUS_WIN_1 = BUS_WIN_SHORT,
    parameter logic [CNT_W-1:0] BUS_WIN_2 = BUS_WIN_MID,
    parameter logic [CNT_W-1:0] BUS_WIN_3 = BUS_WIN_LONG
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Slow watchdog clock, asynchronous to clk
    input  wire logic              low_power_osc,
    // Device modes
    input  wire logic              stop_mode,
    input  wire logic              debug_mode,
    // Causes of the reset now in progress, from the reset controller
    input  wire logic              por_cause,
    input  wire logic              pin_cause,
    input  wire logic              lvd_cause,
    input  wire logic              ilop_cause,
    input  wire logic              ilad_cause,
    // Reset request and status
    output logic                   wdog_reset_req,
    output logic                   wdog_running
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic [1:0]        tsel;
        logic              clksel;
        logic              win_en;
        logic              lock_one;
        logic              lock_two;
        logic              armed;
        logic              req;
        logic              in_rst;
        logic              srs_por;
        logic              srs_pin;
        logic              srs_wdog;
        logic              srs_ilop;
        logic              srs_ilad;
        logic              srs_lvd;
        logic              running;
        logic [DATA_W-1:0] rdata;
    } wdt_state_t;

    wdt_state_t s_q;
    wdt_state_t s_d;

    logic             lpo_tick;
    logic [CNT_W-1:0] count;
    logic             cnt_clear;
    logic             cnt_inc;
    logic             enabled;
    logic             paused;
    logic             windowed;
    logic             overflow;
    logic             win_open;
    logic             wr_status;
    logic             bad_write;
    logic             serviced;
    logic [CNT_W-1:0] ovf_limit;
    logic [CNT_W-1:0] win_min;

    // ========================================================================
    // Decode helpers
    // ========================================================================
    // Overflow count for a clock choice and timeout code
    function automatic logic [CNT_W-1:0] limit_of(input logic clksel, input logic [1:0] tsel);
        logic [CNT_W-1:0] r;
        r = '0;
        case (tsel)
            TSEL_SHORT: r = (clksel == CLKSEL_BUS) ? BUS_OVF_1 : LPO_OVF_SHORT;
            TSEL_MID:   r = (clksel == CLKSEL_BUS) ? BUS_OVF_2 : LPO_OVF_MID;
            default:    r = (clksel == CLKSEL_BUS) ? BUS_OVF_3 : LPO_OVF_LONG;
        endcase
        return r;
    endfunction : limit_of

    // Earliest count at which a windowed service is legal
    function automatic logic [CNT_W-1:0] window_of(input logic [1:0] tsel);
        logic [CNT_W-1:0] r;
        r = '0;
        case (tsel)
            TSEL_SHORT: r = BUS_WIN_1;
            TSEL_MID:   r = BUS_WIN_2;
            default:    r = BUS_WIN_3;
        endcase
        return r;
    endfunction : window_of

    // ========================================================================
    // Slow clock capture and counter
    // ========================================================================
    wdt_lpo_sync u_sync (
        .clk      (clk),
        .rst      (rst),
        .lpo_in   (low_power_osc),
        .lpo_tick (lpo_tick)
    );

    wdt_counter #(
        .W (CNT_W)
    ) u_cnt (
        .clk   (clk),
        .rst   (rst),
        .clear (cnt_clear),
        .inc   (cnt_inc),
        .count (count)
    );

    // ========================================================================
    // Counting and service decode
    // ========================================================================
    always_comb begin
        enabled   = (s_q.tsel != TSEL_OFF);
        paused    = stop_mode || debug_mode;
        windowed  = (s_q.clksel == CLKSEL_BUS) && s_q.win_en;
        ovf_limit = limit_of(s_q.clksel, s_q.tsel);
        win_min   = window_of(s_q.tsel);
        win_open  = !windowed || (count >= win_min);
        wr_status = reg_wr && (reg_addr == ADDR_RESET_STATUS);
        // Bus clock counts each cycle; slow clock counts accepted edges
        if (s_q.clksel == CLKSEL_BUS) begin
            cnt_inc = enabled && !paused;
        end else begin
            cnt_inc = enabled && !paused && lpo_tick;
        end
        overflow  = cnt_inc && (count == ovf_limit - CNT_W'(1));
        // A bad value, or a key outside the window, is illegal
        bad_write = wr_status && (((reg_wdata != KEY_FIRST) && (reg_wdata != KEY_SECOND))
                    || !win_open);
        serviced  = wr_status && !bad_write && (reg_wdata == KEY_SECOND) && s_q.armed;
        // Slow clock loses its count during stop or debug
        cnt_clear = serviced || !enabled
                    || ((s_q.clksel == CLKSEL_LPO) && paused);
    end

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        s_d = s_q;
        s_d.rdata = '0;

        // Register reads; the status word is never written by software
        if (reg_rd) begin
            case (reg_addr)
                ADDR_RESET_STATUS: begin
                    s_d.rdata[SRS_POR_BIT]  = s_q.srs_por;
                    s_d.rdata[SRS_PIN_BIT]  = s_q.srs_pin;
                    s_d.rdata[SRS_WDOG_BIT] = s_q.srs_wdog;
                    s_d.rdata[SRS_ILOP_BIT] = s_q.srs_ilop;
                    s_d.rdata[SRS_ILAD_BIT] = s_q.srs_ilad;
                    s_d.rdata[SRS_LVD_BIT]  = s_q.srs_lvd;
                end
                ADDR_SYS_OPT_ONE: begin
                    s_d.rdata[SYSTEM_OPTIONS_ONE_TSEL_LSB +: 2] = s_q.tsel;
                end
                ADDR_SYS_OPT_TWO: begin
                    s_d.rdata[SYSTEM_OPTIONS_TWO_CLKSEL_BIT] = s_q.clksel;
                    s_d.rdata[SYSTEM_OPTIONS_TWO_WIN_BIT]    = s_q.win_en;
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end

        // Write-once option registers
        if (reg_wr && (reg_addr == ADDR_SYS_OPT_ONE) && !s_q.lock_one) begin
            s_d.tsel     = reg_wdata[SYSTEM_OPTIONS_ONE_TSEL_LSB +: 2];
            s_d.lock_one = 1'b1;
        end
        if (reg_wr && (reg_addr == ADDR_SYS_OPT_TWO) && !s_q.lock_two) begin
            s_d.clksel   = reg_wdata[SYSTEM_OPTIONS_TWO_CLKSEL_BIT];
            s_d.win_en   = reg_wdata[SYSTEM_OPTIONS_TWO_WIN_BIT];
            s_d.lock_two = 1'b1;
        end

        // Key sequence: first key arms, any second key disarms
        if (wr_status && !bad_write) begin
            if (reg_wdata == KEY_FIRST) begin
                s_d.armed = 1'b1;
            end else begin
                s_d.armed = 1'b0;
            end
        end

        // Sticky until the reset controller answers with rst
        if (overflow || bad_write) begin
            s_d.req = 1'b1;
        end
        // Follows the code written this cycle, so flag and code never disagree
        s_d.running = (s_d.tsel != TSEL_OFF);
        s_d.in_rst  = 1'b0;

        // Synchronous reset: defaults, and the cause caught on its first cycle
        if (rst) begin
            s_d          = '0;
            s_d.tsel     = TSEL_RESET;
            s_d.clksel   = CLKSEL_RESET;
            s_d.win_en   = WIN_RESET;
            s_d.running  = 1'b1;
            s_d.in_rst   = 1'b1;
            if (s_q.in_rst) begin
                s_d.srs_por  = s_q.srs_por;
                s_d.srs_pin  = s_q.srs_pin;
                s_d.srs_wdog = s_q.srs_wdog;
                s_d.srs_ilop = s_q.srs_ilop;
                s_d.srs_ilad = s_q.srs_ilad;
                s_d.srs_lvd  = s_q.srs_lvd;
            end else begin
                s_d.srs_por  = por_cause;
                s_d.srs_pin  = pin_cause;
                s_d.srs_wdog = s_q.req && !por_cause;                      // power-on drops stale request
                s_d.srs_ilop = ilop_cause;
                s_d.srs_ilad = ilad_cause;
                s_d.srs_lvd  = lvd_cause;
            end
        end
    end

    // ========================================================================
    // State register
    // ========================================================================
    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    // Outputs straight from the state register
    assign reg_rdata      = s_q.rdata;
    assign wdog_reset_req = s_q.req;
    assign wdog_running   = s_q.running;

endmodule : wdt_top
`default_nettype wire
